/* File: hw/gpiop_pkg.sv */
// Constants shared by the general purpose I/O port block.
// Assumes a 32-bit classic Wishbone slave, word-aligned registers.
package gpiop_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned PORT_W_DEF = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_PIN_INPUT = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_DRIVE_VALUE = 8'h08;
  localparam logic [7:0] OFS_MCU_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_DIR_SET = 8'h10;
  localparam logic [7:0] OFS_DIR_CLR = 8'h14;
  localparam logic [7:0] OFS_DRV_SET = 8'h18;
  localparam logic [7:0] OFS_DRV_CLR = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int unsigned PUD_BIT = 0;
  localparam logic RST_PUD = 1'b0;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // Decoded register select
  typedef enum {
    GPIOP_SEL_PIN,
    GPIOP_SEL_DIR,
    GPIOP_SEL_DRV,
    GPIOP_SEL_MCU,
    GPIOP_SEL_DIR_SET,
    GPIOP_SEL_DIR_CLR,
    GPIOP_SEL_DRV_SET,
    GPIOP_SEL_DRV_CLR,
    GPIOP_SEL_NONE
  } gpiop_sel_t;

endpackage : gpiop_pkg

/* File: hw/gpiop_port.sv */
// General purpose I/O port: drive value, direction, pin input, pull-up control.
// Assumes a classic Wishbone master on mclk and pins resolved outside.
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module gpiop_port #(
  parameter int unsigned PORT_W = gpiop_pkg::PORT_W_DEF
) (
  input wire logic mclk, // System clock, 200 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [gpiop_pkg::ADDR_W-1:0] wb_adr_i, // Byte address
  input wire logic [gpiop_pkg::SEL_W-1:0] wb_sel_i, // Byte lanes
  input wire logic [gpiop_pkg::DATA_W-1:0] wb_dat_i, // Write data
  output logic [gpiop_pkg::DATA_W-1:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [PORT_W-1:0] pin_i, // Pin level in
  output logic [PORT_W-1:0] pin_o, // Pin level out
  output logic [PORT_W-1:0] pin_oe, // Pin output enable, high drives
  output logic [PORT_W-1:0] pin_pullup_en, // Per-pin pull-up enable
  input wire logic [PORT_W-1:0] alt_en, // Alternate function owns pin
  input wire logic [PORT_W-1:0] alt_oe, // Alternate output enable
  input wire logic [PORT_W-1:0] alt_out // Alternate output level
);

  // Port bits live in the low part of one bus word
  if (PORT_W < 1 || PORT_W > gpiop_pkg::DATA_W) begin : g_bad_port_w
    $error("PORT_W must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic gpiop_pkg::gpiop_sel_t gpiop_decode(input logic [gpiop_pkg::ADDR_W-1:0] adr);
    gpiop_pkg::gpiop_sel_t s;
    s = gpiop_pkg::GPIOP_SEL_NONE;
    case (adr)
      gpiop_pkg::OFS_PIN_INPUT: s = gpiop_pkg::GPIOP_SEL_PIN;
      gpiop_pkg::OFS_DIRECTION: s = gpiop_pkg::GPIOP_SEL_DIR;
      gpiop_pkg::OFS_DRIVE_VALUE: s = gpiop_pkg::GPIOP_SEL_DRV;
      gpiop_pkg::OFS_MCU_CONTROL: s = gpiop_pkg::GPIOP_SEL_MCU;
      gpiop_pkg::OFS_DIR_SET: s = gpiop_pkg::GPIOP_SEL_DIR_SET;
      gpiop_pkg::OFS_DIR_CLR: s = gpiop_pkg::GPIOP_SEL_DIR_CLR;
      gpiop_pkg::OFS_DRV_SET: s = gpiop_pkg::GPIOP_SEL_DRV_SET;
      gpiop_pkg::OFS_DRV_CLR: s = gpiop_pkg::GPIOP_SEL_DRV_CLR;
      default: s = gpiop_pkg::GPIOP_SEL_NONE;
    endcase
    return s;
  endfunction : gpiop_decode

  // Write data gated by byte lanes, cut to port width
  function automatic logic [PORT_W-1:0] gpiop_lanes(input logic [gpiop_pkg::SEL_W-1:0] sel,
                                                   input logic [gpiop_pkg::DATA_W-1:0] dat);
    logic [gpiop_pkg::DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < gpiop_pkg::SEL_W; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return PORT_W'(dat & m);
  endfunction : gpiop_lanes

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  gpiop_pkg::gpiop_sel_t bus_sel;
  logic bus_req;
  logic wr_fire;
  logic ack_ff;
  logic [gpiop_pkg::DATA_W-1:0] dat_ff;
  logic [gpiop_pkg::DATA_W-1:0] nxt_dat;
  logic [PORT_W-1:0] wr_bits;
  logic [PORT_W-1:0] lane_mask;
  logic [PORT_W-1:0] dir_ff;
  logic [PORT_W-1:0] drv_ff;
  logic pud_ff;
  logic [PORT_W-1:0] pin_sync;

  assign bus_sel = gpiop_decode(wb_adr_i);
  assign bus_req = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_fire = bus_req && wb_we_i && ack_ff;
  assign wr_bits = gpiop_lanes(wb_sel_i, wb_dat_i);
  assign lane_mask = gpiop_lanes(wb_sel_i, {gpiop_pkg::DATA_W{1'b1}});

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req && !ack_ff;
    end
  end

  always_comb begin
    nxt_dat = gpiop_pkg::RST_WORD;
    case (bus_sel)
      gpiop_pkg::GPIOP_SEL_PIN: nxt_dat[PORT_W-1:0] = pin_sync;
      gpiop_pkg::GPIOP_SEL_DIR: nxt_dat[PORT_W-1:0] = dir_ff;
      gpiop_pkg::GPIOP_SEL_DRV: nxt_dat[PORT_W-1:0] = drv_ff;
      gpiop_pkg::GPIOP_SEL_MCU: nxt_dat[gpiop_pkg::PUD_BIT] = pud_ff;
      default: nxt_dat = gpiop_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dat_ff <= gpiop_pkg::RST_WORD;
    end else if (bus_req && !ack_ff && !wb_we_i) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Port registers

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_ff <= '0;
    end else if (wr_fire) begin
      case (bus_sel)
        gpiop_pkg::GPIOP_SEL_DIR: dir_ff <= (dir_ff & ~lane_mask) | wr_bits;
        gpiop_pkg::GPIOP_SEL_DIR_SET: dir_ff <= dir_ff | wr_bits;
        gpiop_pkg::GPIOP_SEL_DIR_CLR: dir_ff <= dir_ff & ~wr_bits;
        default: dir_ff <= dir_ff;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drv_ff <= '0;
    end else if (wr_fire) begin
      case (bus_sel)
        gpiop_pkg::GPIOP_SEL_DRV: drv_ff <= (drv_ff & ~lane_mask) | wr_bits;
        gpiop_pkg::GPIOP_SEL_PIN: drv_ff <= drv_ff ^ wr_bits;
        gpiop_pkg::GPIOP_SEL_DRV_SET: drv_ff <= drv_ff | wr_bits;
        gpiop_pkg::GPIOP_SEL_DRV_CLR: drv_ff <= drv_ff & ~wr_bits;
        default: drv_ff <= drv_ff;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pud_ff <= gpiop_pkg::RST_PUD;
    end else if (wr_fire && bus_sel == gpiop_pkg::GPIOP_SEL_MCU && wb_sel_i[0]) begin
      pud_ff <= wb_dat_i[gpiop_pkg::PUD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  // Reset gating is combinational so pins float with the clock stopped

  assign pin_oe = rst_n ? ((dir_ff & ~alt_en) | (alt_oe & alt_en)) : '0;
  assign pin_o = rst_n ? ((drv_ff & ~alt_en) | (alt_out & alt_en)) : '0;
  // Per-pin pull-up, killed by global disable or an alternate owner
  assign pin_pullup_en = (rst_n && !pud_ff) ? (drv_ff & ~dir_ff & ~alt_en) : '0;

  gpiop_sync #(
    .PORT_W(PORT_W)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_i(pin_i),
    .pin_sync(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_fire && bus_sel == gpiop_pkg::GPIOP_SEL_PIN |=> drv_ff == ($past(drv_ff) ^ $past(wr_bits)))
    else $error("Pin input write did not toggle drive value");

  AST_PIN_RO: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_fire && bus_sel == gpiop_pkg::GPIOP_SEL_PIN |=> $stable(dir_ff) && $stable(pud_ff))
    else $error("Pin input write disturbed other state");

  AST_DIR_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_fire && bus_sel == gpiop_pkg::GPIOP_SEL_DIR_SET |=> dir_ff == ($past(dir_ff) | $past(wr_bits)))
    else $error("Direction set touched other pins");

  AST_DRV_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_fire && bus_sel == gpiop_pkg::GPIOP_SEL_DRV_CLR |=> drv_ff == ($past(drv_ff) & ~$past(wr_bits)))
    else $error("Drive clear touched other pins");

  AST_PUD_OFF: assert property (@(posedge mclk)
    pud_ff |-> pin_pullup_en == '0)
    else $error("Pull-up on while globally disabled");

  AST_DIR_OE: assert property (@(posedge mclk) disable iff (!rst_n)
    ((pin_oe ^ dir_ff) & ~alt_en) == '0)
    else $error("Output enable does not follow direction");

  AST_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
    ((pin_o ^ drv_ff) & dir_ff & ~alt_en) == '0)
    else $error("Output pin does not drive its drive value");

  AST_PULLUP: assert property (@(posedge mclk) disable iff (!rst_n)
    !pud_ff |-> pin_pullup_en == (drv_ff & ~dir_ff & ~alt_en))
    else $error("Per-pin pull-up enable wrong");

  AST_ALT: assert property (@(posedge mclk) disable iff (!rst_n)
    ((pin_oe ^ alt_oe) & alt_en) == '0 && ((pin_o ^ alt_out) & alt_en) == '0)
    else $error("Alternate function not applied");

  AST_RESET_HIZ: assert property (@(posedge mclk)
    !rst_n |-> pin_oe == '0 && pin_pullup_en == '0)
    else $error("Pins not floating during reset");

  AST_RESET_VAL: assert property (@(posedge mclk)
    rst_n && !$past(rst_n) |-> dir_ff == '0 && drv_ff == '0 && !pud_ff)
    else $error("Registers not zero after reset");

  AST_ACK_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge longer than one cycle");

endmodule : gpiop_port

/* File: hw/gpiop_sync.sv */
// Pin input synchronizer: clock-high transparent latch, then rising-edge flop.
// Assumes pins change away from the falling edge in simulation.
`timescale 1ns/1ps
module gpiop_sync #(
  parameter int unsigned PORT_W = 8
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [PORT_W-1:0] pin_i, // Raw pin levels
  output logic [PORT_W-1:0] pin_sync // Synchronized levels
);

  if (PORT_W < 1) begin : g_bad_port_w
    $error("PORT_W must be at least 1");
  end

  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] sync_ff;

  // Latch closes on the falling edge; only the flop reads it
  always_latch begin
    if (mclk) begin
      latch_q = pin_i;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= latch_q;
    end
  end

  assign pin_sync = sync_ff;

  AST_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> pin_sync == $past(pin_i))
    else $error("Synchronized pin does not follow pin one cycle late");

endmodule : gpiop_sync

/* File: verif/gpiop_pin_model.sv */
// Board-side model of the port pins: resolves each pin from all drivers.
// Assumes one mclk domain and no contention between device and board.
`timescale 1ns/1ps
module gpiop_pin_model #(
  parameter int unsigned PORT_W = 8
) (
  input wire logic mclk, // System clock
  input wire logic [PORT_W-1:0] pin_o, // Device drive level
  input wire logic [PORT_W-1:0] pin_oe, // Device drive enable
  input wire logic [PORT_W-1:0] pin_pullup_en, // Device pull-up enable
  input wire logic [PORT_W-1:0] ext_en, // Board drives the pin
  input wire logic [PORT_W-1:0] ext_val, // Board drive level
  output logic [PORT_W-1:0] pin_lvl // Resolved pin level
);
  logic [PORT_W-1:0] flt_ff = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Floating pins wander so a stale level never reads as valid
  always @(posedge mclk) begin
    flt_ff <= ~flt_ff;
  end

  // Device driver first, then board driver, then pull-up, else floating
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) |
                   (~pin_oe & ~ext_en & pin_pullup_en) | (~pin_oe & ~ext_en & ~pin_pullup_en & flt_ff);
endmodule : gpiop_pin_model

/* File: verif/testbench.sv */
// Self-checking bench for the general purpose I/O port.
// Assumes gpiop_pkg, the port design and the pin model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_n, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [7:0] pin_lvl, pin_o, pin_oe, pull, alt_en, alt_oe, alt_out, ext_en, ext_val;
  int miscompares, checks, cycles;

  gpiop_port #(.PORT_W(8)) gpiop_port_i (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup_en(pull), .alt_en(alt_en),
    .alt_oe(alt_oe), .alt_out(alt_out));
  gpiop_pin_model #(.PORT_W(8)) gpiop_pin_model_i (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pullup_en(pull), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Hang guard, well above the hundred or so cycles the sequence needs
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk

  // Combinational pin outputs are looked at clear of the edge
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, adr, sel, wdat, alt_en, alt_oe, alt_out, ext_val} = '0;
    rst_n = 1'b0;
    ext_en = 8'h50;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    #1;
    chk({24'h0, pin_oe | pull}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(gpiop_pkg::OFS_DIRECTION, 32'h0);
    rd_chk(gpiop_pkg::OFS_DRIVE_VALUE, 32'h0);
    wb(1'b1, gpiop_pkg::OFS_DIRECTION, 32'h0f);
    wb(1'b1, gpiop_pkg::OFS_DRIVE_VALUE, 32'ha5);
    rd_chk(gpiop_pkg::OFS_DIRECTION, 32'h0f);
    rd_chk(gpiop_pkg::OFS_DRIVE_VALUE, 32'ha5);
    settle();
    chk({24'h0, pin_oe}, 32'h0f);
    chk({24'h0, pin_o & pin_oe}, 32'h05);
    chk({24'h0, pull}, 32'ha0);
    // Outputs loop back, bits 5 and 7 pulled up, bits 4 and 6 held low
    rd_chk(gpiop_pkg::OFS_PIN_INPUT, 32'ha5);
    wb(1'b1, gpiop_pkg::OFS_PIN_INPUT, 32'hff);
    rd_chk(gpiop_pkg::OFS_DRIVE_VALUE, 32'h5a);
    wb(1'b1, gpiop_pkg::OFS_PIN_INPUT, 32'h0f);
    rd_chk(gpiop_pkg::OFS_DRIVE_VALUE, 32'h55);
    wb(1'b1, gpiop_pkg::OFS_DIR_SET, 32'h80);
    wb(1'b1, gpiop_pkg::OFS_DIR_CLR, 32'h01);
    rd_chk(gpiop_pkg::OFS_DIRECTION, 32'h8e);
    // No byte lane enabled: the write must not land
    wb(1'b1, gpiop_pkg::OFS_DIRECTION, 32'hff, 4'h0);
    rd_chk(gpiop_pkg::OFS_DIRECTION, 32'h8e);
    rd_chk(gpiop_pkg::OFS_DIR_SET, 32'h0);
    wb(1'b1, gpiop_pkg::OFS_DRV_SET, 32'h02);
    wb(1'b1, gpiop_pkg::OFS_DRV_CLR, 32'h04);
    rd_chk(gpiop_pkg::OFS_DRIVE_VALUE, 32'h53);
    settle();
    chk({24'h0, pull}, 32'h51);
    wb(1'b1, gpiop_pkg::OFS_MCU_CONTROL, 32'h1);
    settle();
    chk({24'h0, pull}, 32'h0);
    rd_chk(gpiop_pkg::OFS_MCU_CONTROL, 32'h1);
    wb(1'b1, gpiop_pkg::OFS_MCU_CONTROL, 32'h0);
    @(posedge mclk);
    alt_en <= 8'h01;
    alt_oe <= 8'h01;
    alt_out <= 8'h01;
    settle();
    chk({24'h0, pin_oe}, 32'h8f);
    chk({24'h0, pin_o & pin_oe}, 32'h03);
    chk({24'h0, pull}, 32'h50);
    rd_chk(8'h40, 32'h0);
    // Second reset in mid-run: pins must let go before any further edge
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    chk({24'h0, pin_oe | pull}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(gpiop_pkg::OFS_DRIVE_VALUE, 32'h0);
    wrap_up();
  end
endmodule : testbench
